/* File: design/taeicr_pkg.sv */
// Shared constants and state types for the event-driven 16-bit timer block.
package taeicr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 6;
    localparam int          CMP_CH      = 3;
    localparam logic [5:0]  OFF_EVCTL   = 6'h09;
    localparam logic [5:0]  OFF_INTEN   = 6'h0a;
    localparam logic [5:0]  OFF_INTFLG  = 6'h0b;
    localparam logic [5:0]  OFF_DBG     = 6'h0e;
    localparam logic [5:0]  OFF_TEMP    = 6'h0f;
    localparam logic [5:0]  OFF_CNT     = 6'h20;
    localparam logic [5:0]  OFF_PER     = 6'h26;
    localparam logic [5:0]  OFF_CMP0    = 6'h28;
    localparam logic [5:0]  OFF_PERIOD_BUFFER  = 6'h36;
    localparam logic [5:0]  OFF_CMPBUF0 = 6'h38;
    localparam logic [5:0]  WORD_STRIDE = 6'h02;
    localparam logic [5:0]  HI_OFS      = 6'h01;

    // ------------------------------------------------------------
    // Field positions, masks and codes
    // ------------------------------------------------------------
    localparam int          EV_EN_BIT   = 0;
    localparam int          EV_ACT_LSB  = 1;
    localparam int          IEN_CMP_LSB = 4;
    localparam int          DBG_RUN_BIT = 0;
    localparam logic [7:0]  EVCTL_MASK  = 8'h07;
    localparam logic [7:0]  INT_MASK    = 8'h71;
    localparam logic [1:0]  ACT_RISE    = 2'h0;
    localparam logic [1:0]  ACT_BOTH    = 2'h1;
    localparam logic [1:0]  ACT_HIGH    = 2'h2;
    localparam logic [1:0]  ACT_UPDN    = 2'h3;
    localparam logic [2:0]  WG_NORMAL   = 3'h0;
    localparam logic [2:0]  WG_FRQ      = 3'h1;
    localparam logic [2:0]  WG_SINGLE   = 3'h3;
    localparam logic [2:0]  WG_DSBOTH   = 3'h6;
    localparam logic [2:0]  WG_DSBOT    = 3'h7;

    // ------------------------------------------------------------
    // Reset values and state types
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_RST     = 16'h0000;
    localparam logic [15:0] PER_RST     = 16'hffff;

    typedef struct packed {
        logic [15:0]              cnt;
        logic [15:0]              period_top;
        logic [15:0]              period_buffer;
        logic [CMP_CH-1:0][15:0]  cmp;
        logic [CMP_CH-1:0][15:0]  cmpbuf;
        logic [2:0]               evctl;
        logic [3:0]               ien;
        logic                     run_dbg;
        logic [7:0]               temp;
        logic                     pbv;
        logic [CMP_CH-1:0]        cbv;
        logic [7:0]               rdata;
    } taeicr_state_t;

    localparam taeicr_state_t ST_RESET = '{cnt: CNT_RST, period_top: PER_RST, period_buffer: PER_RST,
                                           default: '0};

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
        logic fall;
    } taeicr_sync_t;

endpackage

/* File: design/taeicr_event_sync.sv */
// Event input synchroniser with a qualified level and edge pulses.
`timescale 1ns/1ps
module taeicr_event_sync
    import taeicr_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Event line
    input  wire logic ev_async,
    // Qualified outputs
    output logic      ev_level,
    output logic      ev_rise,
    output logic      ev_fall
);

    taeicr_sync_t st_reg;
    taeicr_sync_t st_next;

    // ------------------------------------------------------------
    // Three-stage sampling; a change counts once stages two and three agree.
    // ------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.s1   = ev_async;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        st_next.rise = 1'b0;
        st_next.fall = 1'b0;
        if (st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.lvl) begin
            st_next.lvl  = st_reg.s3;
            st_next.rise = st_reg.s3;
            st_next.fall = ~st_reg.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ev_level = st_reg.lvl;
    assign ev_rise  = st_reg.rise;
    assign ev_fall  = st_reg.fall;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_edge_single;
        @(posedge clk) disable iff (reset)
        (ev_rise || ev_fall) |=> !(ev_rise || ev_fall);
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("edge pulse longer than one cycle");

    property p_rise_level;
        @(posedge clk) disable iff (reset)
        ev_rise |-> ev_level && !$past(ev_level);
    endproperty
    a_rise_level: assert property (p_rise_level) else $error("rise pulse without level change");

    c_rise: cover property (@(posedge clk) disable iff (reset) ev_rise);

endmodule

/* File: design/taeicr_flag_bank.sv */
// Sticky interrupt flags with write-one-to-clear and enable gating.
`timescale 1ns/1ps
module taeicr_flag_bank
    import taeicr_pkg::*;
#(
    parameter int W = 4
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Flag control
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    input  wire logic [W-1:0] en,
    // Status
    output logic [W-1:0]      flags,
    output logic [W-1:0]      irq
);

    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // ------------------------------------------------------------
    // Set wins over a clear in the same cycle.
    // ------------------------------------------------------------
    always_comb begin
        flags_next = (flags_reg & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
    assign irq   = flags_reg & en;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_flag_sticky;
        @(posedge clk) disable iff (reset)
        ##1 (($past(flags) & ~$past(clr)) & ~flags) == '0;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared on its own");

    property p_set_wins;
        @(posedge clk) disable iff (reset)
        (set != '0) |=> ((flags & $past(set)) == $past(set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set was lost");

    property p_irq_gate;
        @(posedge clk) disable iff (reset)
        (en == '0) |-> (irq == '0);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

endmodule

/* File: design/taeicr_top.sv */
// Event-driven 16-bit timer with byte register access, flags and buffered loads.
//
// Behaviour
// - Compare buffer write sets its valid bit; a buffer load clears it.
// - Period buffer write sets period valid bit; next buffer load clears it.
// - Event counting steps on rising edges (code 0) or both edges (code 1).
// - Action code 2 counts prescaled ticks only while the event line is high.
// - Action code 3 counts every tick, up when event low, down when high.
// - Event count enable off means the event line does not affect counting.
// - Three compare enables let each compare flag raise its request.
// - Overflow enable lets the overflow/underflow flag raise its request.
// - A compare flag sets when a counter step takes the counter to that channel's compare value.
// - Compare flags stay set until software writes one to them.
// - Overflow flag sets at top, bottom or both, per waveform mode.
// - Overflow flag stays set until software writes one to it.
// - Without run-in-debug the timer halts and ignores events in break debug.
// - One shared 8-bit temporary byte serves all 16-bit registers.
// - Each 16-bit register has low byte at base, high at base plus one.
// - A software counter write beats a same-cycle counter step.
// - Period register holds the top value except in WG_FRQ mode, where compare 0 does; it resets to all ones.
// - Counter is a readable, writable 16-bit register at 0x20, reset zero.
// - On a buffer load, compare registers whose valid bit is set take their buffer values.
// - Lock update blocks buffer loads and keeps the valid bits set.
`timescale 1ns/1ps
module taeicr_top
    import taeicr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    // Timer control
    input  wire logic              timer_enable,
    input  wire logic              prescale_tick,
    input  wire logic              count_down,
    input  wire logic [2:0]        waveform_mode,
    input  wire logic              lock_update,
    input  wire logic              debug_halt,
    // Event line
    input  wire logic              event_in,
    // Requests
    output logic                   ovf_irq,
    output logic [CMP_CH-1:0]      cmp_irq
);

    taeicr_state_t     st_reg;
    taeicr_state_t     st_next;
    logic              ev_level;
    logic              ev_rise;
    logic              ev_fall;
    logic [3:0]        flags;
    logic [3:0]        irq;
    logic [3:0]        flag_set;
    logic [3:0]        flag_clr;
    logic              run;
    logic              step;
    logic              down;
    logic              top_ev;
    logic              bot_ev;
    logic              upd;
    logic [15:0]       top;
    logic [15:0]       cnt_step;
    logic [15:0]       rd_word;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] wide_base(input int k);
        if (k == 0) begin
            return OFF_CNT;
        end else if (k == 1) begin
            return OFF_PER;
        end else if (k == 2) begin
            return OFF_PERIOD_BUFFER;
        end else if (k < 6) begin
            return OFF_CMP0 + 6'((k - 3) * 2);
        end else begin
            return OFF_CMPBUF0 + 6'((k - 6) * 2);
        end
    endfunction

    function automatic logic [15:0] wide_read(input taeicr_state_t s, input int k);
        if (k == 0) begin
            return s.cnt;
        end else if (k == 1) begin
            return s.period_top;
        end else if (k == 2) begin
            return s.period_buffer;
        end else if (k < 6) begin
            return s.cmp[k-3];
        end else begin
            return s.cmpbuf[k-6];
        end
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    taeicr_event_sync u_sync (
        .clk      (clk),
        .reset    (reset),
        .ev_async (event_in),
        .ev_level (ev_level),
        .ev_rise  (ev_rise),
        .ev_fall  (ev_fall)
    );

    taeicr_flag_bank #(.W(4)) u_flags (
        .clk   (clk),
        .reset (reset),
        .set   (flag_set),
        .clr   (flag_clr),
        .en    (st_reg.ien),
        .flags (flags),
        .irq   (irq)
    );

    assign ovf_irq = irq[0];
    assign cmp_irq = irq[3:1];

    // ------------------------------------------------------------
    // Count engine
    // ------------------------------------------------------------
    always_comb begin
        run  = timer_enable & (~debug_halt | st_reg.run_dbg);
        step = prescale_tick;
        down = count_down;
        if (st_reg.evctl[EV_EN_BIT]) begin
            case (st_reg.evctl[EV_ACT_LSB +: 2])
                ACT_RISE: step = ev_rise;
                ACT_BOTH: step = ev_rise | ev_fall;
                ACT_HIGH: step = prescale_tick & ev_level;
                default: begin
                    step = prescale_tick;
                    down = ev_level;
                end
            endcase
        end
        step     = step & run;
        top      = (waveform_mode == WG_FRQ) ? st_reg.cmp[0] : st_reg.period_top;
        top_ev   = step & ~down & (st_reg.cnt == top);
        bot_ev   = step & down & (st_reg.cnt == CNT_RST);
        if (down) begin
            cnt_step = (st_reg.cnt == CNT_RST) ? top : st_reg.cnt - 16'h0001;
        end else begin
            cnt_step = (st_reg.cnt == top) ? CNT_RST : st_reg.cnt + 16'h0001;
        end
        upd = (waveform_mode == WG_NORMAL || waveform_mode == WG_FRQ) ? top_ev : bot_ev;
        case (waveform_mode)
            WG_SINGLE, WG_DSBOT: flag_set[0] = bot_ev;
            WG_DSBOTH:           flag_set[0] = top_ev | bot_ev;
            default:             flag_set[0] = top_ev;
        endcase
        for (int n = 0; n < CMP_CH; n++) begin
            flag_set[n+1] = step & (cnt_step == st_reg.cmp[n]);
        end
        flag_clr = '0;
        if (reg_wr && reg_addr == OFF_INTFLG) begin
            flag_clr = {reg_wdata[IEN_CMP_LSB +: CMP_CH], reg_wdata[0]};
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        rd_word = 16'h0000;
        if (step) begin
            st_next.cnt = cnt_step;
        end
        if (upd && !lock_update) begin
            if (st_reg.pbv) begin
                st_next.period_top = st_reg.period_buffer;
            end
            for (int n = 0; n < CMP_CH; n++) begin
                if (st_reg.cbv[n]) begin
                    st_next.cmp[n] = st_reg.cmpbuf[n];
                end
            end
            st_next.pbv = 1'b0;
            st_next.cbv = '0;
        end
        if (reg_wr) begin
            if (reg_addr == OFF_EVCTL) begin
                st_next.evctl = reg_wdata[2:0];
            end else if (reg_addr == OFF_INTEN) begin
                st_next.ien = {reg_wdata[IEN_CMP_LSB +: CMP_CH], reg_wdata[0]};
            end else if (reg_addr == OFF_DBG) begin
                st_next.run_dbg = reg_wdata[DBG_RUN_BIT];
            end else if (reg_addr == OFF_TEMP) begin
                st_next.temp = reg_wdata;
            end else if (reg_addr == OFF_CNT) begin
                st_next.cnt = {st_reg.temp, reg_wdata};
            end else if (reg_addr == OFF_PER) begin
                st_next.period_top = {st_reg.temp, reg_wdata};
            end else if (reg_addr == OFF_PERIOD_BUFFER) begin
                st_next.period_buffer = {st_reg.temp, reg_wdata};
                st_next.pbv    = 1'b1;
            end else begin
                for (int n = 0; n < CMP_CH; n++) begin
                    if (reg_addr == OFF_CMP0 + 6'(n * 2)) begin
                        st_next.cmp[n] = {st_reg.temp, reg_wdata};
                    end
                    if (reg_addr == OFF_CMPBUF0 + 6'(n * 2)) begin
                        st_next.cmpbuf[n] = {st_reg.temp, reg_wdata};
                        st_next.cbv[n]    = 1'b1;
                    end
                end
                for (int k = 0; k < 9; k++) begin
                    if (reg_addr == wide_base(k) + HI_OFS) begin
                        st_next.temp = reg_wdata;
                    end
                end
            end
        end
        if (reg_rd) begin
            st_next.rdata = 8'h00;
            if (reg_addr == OFF_EVCTL) begin
                st_next.rdata = {5'h00, st_reg.evctl} & EVCTL_MASK;
            end else if (reg_addr == OFF_INTEN) begin
                st_next.rdata = {1'b0, st_reg.ien[3:1], 3'h0, st_reg.ien[0]} & INT_MASK;
            end else if (reg_addr == OFF_INTFLG) begin
                st_next.rdata = {1'b0, flags[3:1], 3'h0, flags[0]};
            end else if (reg_addr == OFF_DBG) begin
                st_next.rdata = {7'h00, st_reg.run_dbg};
            end else if (reg_addr == OFF_TEMP) begin
                st_next.rdata = st_reg.temp;
            end else begin
                for (int k = 0; k < 9; k++) begin
                    if (reg_addr == wide_base(k)) begin
                        rd_word       = wide_read(st_reg, k);
                        st_next.rdata = rd_word[7:0];
                        st_next.temp  = rd_word[15:8];
                    end
                    if (reg_addr == wide_base(k) + HI_OFS) begin
                        st_next.rdata = st_reg.temp;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_values;
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> st_reg.cnt == 16'h0000 && st_reg.period_top == 16'hffff;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");

    property p_cnt_write_wins;
        @(posedge clk) disable iff (reset)
        (reg_wr && reg_addr == OFF_CNT) |=> st_reg.cnt == {$past(st_reg.temp), $past(reg_wdata)};
    endproperty
    a_cnt_write_wins: assert property (p_cnt_write_wins) else $error("counter write lost");

    property p_buf_valid_set;
        @(posedge clk) disable iff (reset)
        (reg_wr && reg_addr == OFF_CMPBUF0) |=> st_reg.cbv[0] ##0 st_reg.cmpbuf[0][7:0] == $past(reg_wdata);
    endproperty
    a_buf_valid_set: assert property (p_buf_valid_set) else $error("buffer valid not set");

    property p_lock_holds;
        @(posedge clk) disable iff (reset)
        lock_update |=> ((st_reg.cbv & $past(st_reg.cbv)) == $past(st_reg.cbv)) && $stable(st_reg.period_top) || $past(reg_wr);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("load under lock");

    property p_load_cmp;
        @(posedge clk) disable iff (reset)
        (upd && !lock_update && st_reg.cbv[0] && !reg_wr) |=> st_reg.cmp[0] == $past(st_reg.cmpbuf[0]) && !st_reg.cbv[0];
    endproperty
    a_load_cmp: assert property (p_load_cmp) else $error("compare not loaded");

    property p_high_level_gate;
        @(posedge clk) disable iff (reset)
        (st_reg.evctl == 3'h5 && !ev_level && !reg_wr) |=> $stable(st_reg.cnt);
    endproperty
    a_high_level_gate: assert property (p_high_level_gate) else $error("counted while low");

    property p_updown;
        @(posedge clk) disable iff (reset)
        (st_reg.evctl == 3'h7 && run && prescale_tick && !ev_level && st_reg.cnt != top && !reg_wr)
            |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001;
    endproperty
    a_updown: assert property (p_updown) else $error("no up count on low event");

    property p_debug_halt;
        @(posedge clk) disable iff (reset)
        (debug_halt && !st_reg.run_dbg && !reg_wr) |=> $stable(st_reg.cnt);
    endproperty
    a_debug_halt: assert property (p_debug_halt) else $error("ran while halted");

    property p_low_read_latch;
        @(posedge clk) disable iff (reset)
        (reg_rd && reg_addr == OFF_CNT) |=> st_reg.temp == $past(st_reg.cnt[15:8]);
    endproperty
    a_low_read_latch: assert property (p_low_read_latch) else $error("temp not latched");

    c_overflow: cover property (@(posedge clk) disable iff (reset) flag_set[0]);
    c_match: cover property (@(posedge clk) disable iff (reset) flag_set[1]);
    c_update: cover property (@(posedge clk) disable iff (reset) upd && st_reg.pbv && !lock_update);

endmodule

/* File: tb/taeicr_event_src.sv */
// Event routing model that drives the timer's event line.
`timescale 1ns/1ps
module taeicr_event_src
    import taeicr_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Event line
    output logic      event_in
);
    initial event_in = 1'b0;
    // Sets the event level after a clock edge and holds it for the given cycles.
    task automatic drive(input logic lvl, input int hold);
        @(posedge clk);
        event_in <= lvl;
        repeat (hold) @(posedge clk);
    endtask
endmodule

/* File: tb/tb_taeicr_top.sv */
// Self-checking bench for the event-driven timer block.
`timescale 1ns/1ps
module tb_taeicr_top
    import taeicr_pkg::*;
;
    // ------------------------
    // Signals and instances
    // ------------------------
    logic              clk           = 1'b0;
    logic              reset         = 1'b1;
    logic [ADDR_W-1:0] reg_addr      = '0;
    logic              reg_wr        = 1'b0;
    logic              reg_rd        = 1'b0;
    logic [7:0]        reg_wdata     = 8'h00;
    logic              prescale_tick = 1'b0;
    logic              lock_update   = 1'b0;
    logic              debug_halt    = 1'b0;
    logic [2:0]        waveform_mode = WG_NORMAL;
    logic              count_down    = 1'b0;
    logic [7:0]        reg_rdata;
    logic              event_in;
    logic              ovf_irq;
    logic [CMP_CH-1:0] cmp_irq;
    logic [7:0]        b;
    logic [15:0]       v;
    int                num_errors    = 0;
    int                cmp_count     = 0;
    int                cycles        = 0;
    logic [31:0]       rows [10]     = '{32'h26ffffff, 32'h27ffffff, 32'h20000000,
        32'h21000000, 32'h0900ff07, 32'h0a00ff71, 32'h0b00ff00, 32'h0e00ff01,
        32'h0f00a5a5, 32'h1000ff00};
    taeicr_top taeicr_top_i (
        .clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .timer_enable(1'b1), .prescale_tick(prescale_tick), .count_down(count_down),
        .waveform_mode(waveform_mode), .lock_update(lock_update), .debug_halt(debug_halt),
        .event_in(event_in), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq)
    );
    taeicr_event_src taeicr_event_src_i (.clk(clk), .event_in(event_in));
    always #20 clk = ~clk;
    // ------------------------
    // Tasks and test sequence
    // ------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic wr16(input logic [5:0] a, input logic [15:0] w);
        wr(a + HI_OFS, w[15:8]);
        wr(a, w[7:0]);
    endtask
    task automatic rd16(input logic [5:0] a, output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + HI_OFS, hi);
        w = {hi, lo};
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            prescale_tick <= 1'b1;
            @(posedge clk);
            prescale_tick <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            taeicr_event_src_i.drive(1'b1, 8);
            taeicr_event_src_i.drive(1'b0, 8);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            rd(rows[i][29:24], b);
            chk({8'h00, b}, {8'h00, rows[i][23:16]});
            wr(rows[i][29:24], rows[i][15:8]);
            rd(rows[i][29:24], b);
            chk({8'h00, b}, {8'h00, rows[i][7:0]});
        end
        $display("register table done");
        wr(OFF_CNT + HI_OFS, 8'h12);
        wr(OFF_CNT, 8'h34);
        rd(OFF_CNT, b);
        chk({8'h00, b}, 16'h0034);
        rd(OFF_TEMP, b);
        chk({8'h00, b}, 16'h0012);
        rd(OFF_CNT + HI_OFS, b);
        chk({8'h00, b}, 16'h0012);
        $display("wide access done");
        wr16(OFF_CNT, 16'h0000);
        wr(OFF_DBG, 8'h00);
        wr(OFF_EVCTL, 8'h01);
        pulses(3);
        rd16(OFF_CNT, v);
        chk(v, 16'h0003);
        wr(OFF_EVCTL, 8'h03);
        pulses(2);
        rd16(OFF_CNT, v);
        chk(v, 16'h0007);
        wr(OFF_EVCTL, 8'h02);
        pulses(2);
        rd16(OFF_CNT, v);
        chk(v, 16'h0007);
        wr(OFF_EVCTL, 8'h05);
        taeicr_event_src_i.drive(1'b1, 8);
        tick(4);
        taeicr_event_src_i.drive(1'b0, 8);
        tick(4);
        rd16(OFF_CNT, v);
        chk(v, 16'h000b);
        wr(OFF_EVCTL, 8'h07);
        tick(3);
        taeicr_event_src_i.drive(1'b1, 8);
        tick(5);
        taeicr_event_src_i.drive(1'b0, 8);
        rd16(OFF_CNT, v);
        chk(v, 16'h0009);
        wr(OFF_EVCTL, 8'h00);
        $display("event counting done");
        wr(OFF_INTFLG, 8'h71);
        wr16(OFF_PER, 16'h0006);
        wr16(OFF_CMP0, 16'h0005);
        wr16(OFF_CNT, 16'h0003);
        wr(OFF_INTEN, 8'h11);
        tick(2);
        chk({13'h0000, cmp_irq}, 16'h0001);
        tick(2);
        chk({15'h0000, ovf_irq}, 16'h0001);
        rd(OFF_INTFLG, b);
        chk({8'h00, b}, 16'h0071);
        wr(OFF_INTFLG, 8'h00);
        rd(OFF_INTFLG, b);
        chk({8'h00, b}, 16'h0071);
        wr(OFF_INTFLG, 8'h11);
        rd(OFF_INTFLG, b);
        chk({8'h00, b}, 16'h0060);
        chk({12'h000, cmp_irq, ovf_irq}, 16'h0000);
        $display("flags done");
        lock_update <= 1'b1;
        wr16(OFF_PERIOD_BUFFER, 16'h0003);
        wr16(OFF_CMPBUF0 + WORD_STRIDE, 16'h0002);
        wr16(OFF_CMPBUF0, 16'h0005);
        tick(7);
        rd16(OFF_CMP0 + WORD_STRIDE, v);
        chk(v, 16'h0000);
        lock_update <= 1'b0;
        tick(7);
        rd16(OFF_PER, v);
        chk(v, 16'h0003);
        rd16(OFF_CMP0 + WORD_STRIDE, v);
        chk(v, 16'h0002);
        wr16(OFF_CMP0 + WORD_STRIDE, 16'h0008);
        tick(4);
        rd16(OFF_CMP0 + WORD_STRIDE, v);
        chk(v, 16'h0008);
        $display("buffer load done");
        debug_halt <= 1'b1;
        wr(OFF_DBG, 8'h00);
        tick(2);
        rd16(OFF_CNT, v);
        chk(v, 16'h0000);
        wr(OFF_DBG, 8'h01);
        tick(2);
        rd16(OFF_CNT, v);
        chk(v, 16'h0002);
        debug_halt <= 1'b0;
        wr(OFF_CNT + HI_OFS, 8'h00);
        prescale_tick <= 1'b1;
        reg_addr      <= OFF_CNT;
        reg_wdata     <= 8'h01;
        reg_wr        <= 1'b1;
        @(posedge clk);
        prescale_tick <= 1'b0;
        reg_wr        <= 1'b0;
        @(posedge clk);
        rd16(OFF_CNT, v);
        chk(v, 16'h0001);
        $display("debug and write priority done");
        wr(OFF_INTFLG, 8'h71);
        waveform_mode <= WG_SINGLE;
        count_down    <= 1'b1;
        tick(2);
        rd(OFF_INTFLG, b);
        chk({8'h00, b}, 16'h0041);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd16(OFF_CNT, v);
        chk(v, 16'h0000);
        rd16(OFF_PER, v);
        chk(v, 16'hffff);
        $display("mode and reset done");
        finish_test();
    end
endmodule
